// file: include/dac_serial_control_pkg.sv
package dac_serial_control_pkg;
    localparam int CMD_W = 24;
    localparam int PAYLOAD_W = 20;
    localparam int CODE_W = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FRAME_BITS = 5'h18;
    localparam logic [CNT_W-1:0] OVER_BITS = 5'h19;

    // command word fields
    localparam int RW_BIT = 23;
    localparam int ADDR_MSB = 22;
    localparam int ADDR_LSB = 20;
    localparam int CODE_MSB = 19;
    localparam int CODE_LSB = 4;

    // register addresses
    localparam logic [2:0] ADDR_NO_OPERATION = 3'h0;
    localparam logic [2:0] ADDR_DAC = 3'h1;
    localparam logic [2:0] ADDR_CTRL = 3'h2;
    localparam logic [2:0] ADDR_CLRC = 3'h3;
    localparam logic [2:0] ADDR_SWCTL = 3'h4;

    // control register bits
    localparam int CTRL_AMP_BYPASS_BIT = 1;
    localparam int CTRL_CLAMP_BIT = 2;
    localparam int CTRL_TRI_BIT = 3;
    localparam int CTRL_FMT_BIT = 4;
    localparam int CTRL_DOUT_OFF_BIT = 5;
    localparam logic [PAYLOAD_W-1:0] CTRL_WMASK = 20'h0003E;
    localparam logic [PAYLOAD_W-1:0] CTRL_RESET = 20'h0000E;

    // software control register bits
    localparam int SW_CLEAR_BIT = 1;
    localparam int SW_RESET_BIT = 2;

    localparam logic [CODE_W-1:0] DAC_RESET = 16'h0000;
    localparam logic [CODE_W-1:0] CLRC_RESET = 16'h0000;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_FRAME = 1'b1
    } frame_state_e;
endpackage

// file: verilog/pin_filter.sv
`timescale 1ns/100ps
// three-stage synchroniser; the filtered level only moves once stages two and three agree
module pin_filter #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_pin,
    output logic o_level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic agree;

    assign agree = (s2_q == s3_q);
    assign o_level = level_q;

    // first stage feeds only the second, to keep metastability contained
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
            level_q <= RESET_VAL;
        end else begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= agree ? s3_q : level_q;
        end
    end
endmodule

// file: verilog/dac_serial_control.sv
`timescale 1ns/100ps
module dac_serial_control
    import dac_serial_control_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_frame_sel_n,
    input wire logic i_serial_clk,
    input wire logic i_serial_data_in,
    input wire logic i_load_output_n,
    input wire logic i_clear_to_preset_n,
    input wire logic i_reset_n,
    output logic o_serial_data_out,
    output logic o_serial_data_out_oe,
    output logic [CODE_W-1:0] o_output_code,
    output logic o_output_ground_clamp,
    output logic o_output_tristate,
    output logic o_code_format_select,
    output logic o_amp_bypass
);
    // filtered pin levels
    logic fs_n;
    logic sclk;
    logic din;
    logic load_n;
    logic clear_n;
    logic rst_pin_n;

    pin_filter #(.RESET_VAL(1'b1)) u_fs (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_pin(i_frame_sel_n),
        .o_level(fs_n)
    );
    pin_filter #(.RESET_VAL(1'b0)) u_sclk (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_pin(i_serial_clk),
        .o_level(sclk)
    );
    pin_filter #(.RESET_VAL(1'b0)) u_din (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_pin(i_serial_data_in),
        .o_level(din)
    );
    pin_filter #(.RESET_VAL(1'b1)) u_load (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_pin(i_load_output_n),
        .o_level(load_n)
    );
    pin_filter #(.RESET_VAL(1'b1)) u_clear (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_pin(i_clear_to_preset_n),
        .o_level(clear_n)
    );
    pin_filter #(.RESET_VAL(1'b0)) u_rst (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_pin(i_reset_n),
        .o_level(rst_pin_n)
    );

    // picks the 16-bit code out of a payload; used for DAC and clearcode writes
    function automatic logic [CODE_W-1:0] payload_code(input logic [CMD_W-1:0] cmd);
        payload_code = cmd[CODE_MSB:CODE_LSB];
    endfunction

    // state
    frame_state_e state_q;
    frame_state_e state_d;
    logic fs_prev_q;
    logic sclk_prev_q;
    logic load_prev_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CMD_W-1:0] shift_q;
    logic load_high_seen_q;
    logic [CMD_W-1:0] rd_shift_q;
    logic [CMD_W-1:0] rd_shift_d;
    logic [CODE_W-1:0] dac_q;
    logic [CODE_W-1:0] dac_d;
    logic [CODE_W-1:0] clrc_q;
    logic [CODE_W-1:0] clrc_d;
    logic [PAYLOAD_W-1:0] ctrl_q;
    logic [PAYLOAD_W-1:0] ctrl_d;
    logic [CODE_W-1:0] out_q;
    logic [CODE_W-1:0] out_d;
    logic soft_rst_q;
    logic soft_clr_q;
    logic dout_q;
    logic dout_oe_q;
    logic clamp_q;
    logic tri_q;
    logic fmt_q;
    logic bypass_q;

    // edge detection on filtered levels
    logic fs_fall;
    logic fs_rise;
    logic sclk_fall;
    logic load_fall;
    assign fs_fall = fs_prev_q & ~fs_n;
    assign fs_rise = ~fs_prev_q & fs_n;
    assign sclk_fall = sclk_prev_q & ~sclk;
    assign load_fall = load_prev_q & ~load_n;

    // held in reset by the pin or for one cycle by the soft reset bit
    logic hold_rst;
    assign hold_rst = ~rst_pin_n | soft_rst_q;

    // frame close decode
    logic frame_end;
    logic frame_ok;
    logic is_read;
    logic [2:0] addr;
    assign frame_end = (state_q == ST_FRAME) & fs_rise;
    assign frame_ok = frame_end & (cnt_q == FRAME_BITS);
    assign is_read = shift_q[RW_BIT];
    assign addr = shift_q[ADDR_MSB:ADDR_LSB];

    logic wr_dac;
    logic wr_ctrl;
    logic wr_clrc;
    logic wr_sw;
    logic rd_any;
    assign wr_dac = frame_ok & ~is_read & (addr == ADDR_DAC);
    assign wr_ctrl = frame_ok & ~is_read & (addr == ADDR_CTRL);
    assign wr_clrc = frame_ok & ~is_read & (addr == ADDR_CLRC);
    assign wr_sw = frame_ok & ~is_read & (addr == ADDR_SWCTL);
    assign rd_any = frame_ok & is_read & (addr >= ADDR_DAC) & (addr <= ADDR_CLRC);

    // readback word mirrors the command header with the register payload
    logic [PAYLOAD_W-1:0] rd_payload;
    assign rd_payload = (addr == ADDR_DAC) ? {dac_q, 4'h0} :
                        (addr == ADDR_CTRL) ? (ctrl_q & CTRL_WMASK) :
                        {clrc_q, 4'h0};

    // clear action from pin level or soft bit pulse
    logic clear_act;
    assign clear_act = ~clear_n | soft_clr_q;

    // output update events; clear blocks both
    logic sync_upd;
    logic async_upd;
    assign sync_upd = frame_ok & ~load_high_seen_q & load_n == 1'b0;
    assign async_upd = load_fall & fs_n & (state_q == ST_IDLE);

    // frame state and bit count
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_IDLE: begin
                if (fs_fall) begin
                    state_d = ST_FRAME;
                    cnt_d = '0;
                end
            end
            ST_FRAME: begin
                if (fs_rise) begin
                    state_d = ST_IDLE;
                end else if (sclk_fall && cnt_q != OVER_BITS) begin
                    cnt_d = cnt_q + 5'h01; // saturates one past a full word
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // readback shifter: loaded at the end of a DAC, control or clearcode read frame, shifted on each falling clock
    always_comb begin
        rd_shift_d = rd_shift_q;
        if (rd_any) begin
            rd_shift_d = {1'b1, addr, rd_payload};
        end else if (frame_end) begin
            rd_shift_d = '0; // data is only offered in the frame right after the read
        end else if (state_q == ST_FRAME && sclk_fall) begin
            rd_shift_d = {rd_shift_q[CMD_W-2:0], 1'b0};
        end
    end

    // register next values; clear wins over a DAC write landing in the same cycle
    always_comb begin
        dac_d = dac_q;
        clrc_d = clrc_q;
        ctrl_d = ctrl_q;
        out_d = out_q;
        if (wr_clrc) begin
            clrc_d = payload_code(shift_q);
        end
        if (wr_ctrl) begin
            ctrl_d = shift_q[PAYLOAD_W-1:0] & CTRL_WMASK;
        end
        if (clear_act) begin
            dac_d = clrc_q;
            out_d = clrc_q;
        end else begin
            if (wr_dac) begin
                dac_d = payload_code(shift_q);
            end
            if (sync_upd) begin
                out_d = wr_dac ? payload_code(shift_q) : dac_q;
            end else if (async_upd) begin
                out_d = dac_q;
            end
        end
    end

    // edge history and frame machinery; state is cleared to idle while reset is held
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fs_prev_q <= 1'b1;
            sclk_prev_q <= 1'b0;
            load_prev_q <= 1'b1;
            state_q <= ST_IDLE;
            cnt_q <= '0;
            shift_q <= '0;
            load_high_seen_q <= 1'b0;
            rd_shift_q <= '0;
        end else begin
            fs_prev_q <= fs_n;
            sclk_prev_q <= sclk;
            load_prev_q <= load_n;
            if (hold_rst) begin
                state_q <= ST_IDLE;
                cnt_q <= '0;
                shift_q <= '0;
                load_high_seen_q <= 1'b0;
                rd_shift_q <= '0;
            end else begin
                state_q <= state_d;
                cnt_q <= cnt_d;
                rd_shift_q <= rd_shift_d;
                if (state_q == ST_FRAME && sclk_fall) begin
                    shift_q <= {shift_q[CMD_W-2:0], din};
                end
                if (fs_fall) begin
                    load_high_seen_q <= load_n;
                end else if (state_q == ST_FRAME && load_n) begin
                    load_high_seen_q <= 1'b1;
                end
            end
        end
    end

    // on-chip registers and output latch
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dac_q <= DAC_RESET;
            clrc_q <= CLRC_RESET;
            ctrl_q <= CTRL_RESET;
            out_q <= DAC_RESET;
            soft_rst_q <= 1'b0;
            soft_clr_q <= 1'b0;
        end else if (hold_rst) begin
            dac_q <= DAC_RESET;
            clrc_q <= CLRC_RESET;
            ctrl_q <= CTRL_RESET;
            out_q <= DAC_RESET;
            soft_rst_q <= 1'b0;
            soft_clr_q <= 1'b0;
        end else begin
            dac_q <= dac_d;
            clrc_q <= clrc_d;
            ctrl_q <= ctrl_d;
            out_q <= out_d;
            soft_rst_q <= wr_sw & shift_q[SW_RESET_BIT];
            soft_clr_q <= wr_sw & shift_q[SW_CLEAR_BIT];
        end
    end

    // pin-facing outputs, each from its own flop; the clamp forces tristate
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dout_q <= 1'b0;
            dout_oe_q <= 1'b0;
            clamp_q <= 1'b1;
            tri_q <= 1'b1;
            fmt_q <= 1'b0;
            bypass_q <= 1'b1;
        end else begin
            dout_q <= rd_shift_q[CMD_W-1];
            dout_oe_q <= ~fs_n & ~ctrl_q[CTRL_DOUT_OFF_BIT] & ~hold_rst;
            clamp_q <= ctrl_q[CTRL_CLAMP_BIT];
            tri_q <= ctrl_q[CTRL_CLAMP_BIT] | ctrl_q[CTRL_TRI_BIT];
            fmt_q <= ctrl_q[CTRL_FMT_BIT];
            bypass_q <= ctrl_q[CTRL_AMP_BYPASS_BIT];
        end
    end

    assign o_serial_data_out = dout_q;
    assign o_serial_data_out_oe = dout_oe_q;
    assign o_output_code = out_q;
    assign o_output_ground_clamp = clamp_q;
    assign o_output_tristate = tri_q;
    assign o_code_format_select = fmt_q;
    assign o_amp_bypass = bypass_q;
endmodule

// file: bench/host_model.sv
`timescale 1ns/100ps
// serial host: clock idles low between frames, data line flips once released
module host_model (
    input wire logic i_sys_clk,
    input wire logic i_dout,
    output logic o_sel_n,
    output logic o_sclk,
    output logic o_sdi
);
    initial begin
        o_sel_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi = 1'b0;
    end
    // frame of nf falls; data changes mid low phase so sync lag cannot skew it
    task automatic frame(input logic [23:0] cmd, input int nf, output logic [23:0] rd);
        logic [31:0] w;
        w = {cmd, 8'h00};
        rd = 24'h000000;
        @(negedge i_sys_clk);
        o_sel_n = 1'b0;
        #800;
        for (int k = 0; k < nf; k++) begin
            o_sdi = w[31];
            w = w << 1;
            #200 o_sclk = 1'b1;
            // sampled late in the high phase, the shift lags the fall by ~5 cycles
            #400 rd = {rd[22:0], i_dout};
            o_sclk = 1'b0;
            #200;
        end
        #400 o_sel_n = 1'b1;
        o_sdi = ~o_sdi;
        #1200;
    endtask
endmodule

// file: bench/dac_serial_control_props.sv
`timescale 1ns/100ps
module dac_serial_control_props
    import dac_serial_control_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_frame_sel_n,
    input wire logic i_serial_clk,
    input wire logic i_serial_data_in,
    input wire logic i_load_output_n,
    input wire logic i_clear_to_preset_n,
    input wire logic i_reset_n,
    input wire logic o_serial_data_out,
    input wire logic o_serial_data_out_oe,
    input wire logic [CODE_W-1:0] o_output_code,
    input wire logic o_output_ground_clamp,
    input wire logic o_output_tristate,
    input wire logic o_code_format_select,
    input wire logic o_amp_bypass
);
    logic sel_q;
    logic ld_q;
    logic [3:0] quiet_q;
    // anything that may legally move the outputs restarts the quiet count
    wire logic stir = (i_frame_sel_n && !sel_q) || (ld_q && !i_load_output_n)
        || !i_clear_to_preset_n || !i_reset_n;
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sel_q <= 1'b1;
            ld_q <= 1'b1;
            quiet_q <= 4'h0;
        end else begin
            sel_q <= i_frame_sel_n;
            ld_q <= i_load_output_n;
            quiet_q <= stir ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    chk_oe_idle: assert property (i_frame_sel_n [*8] |-> !o_serial_data_out_oe)
        else $error("data-out driven outside a frame");
    chk_oe_rise: assert property ($rose(o_serial_data_out_oe) |-> !$past(i_frame_sel_n, 3))
        else $error("data-out enabled without a frame");
    chk_reset_defaults: assert property (!i_reset_n [*8] |-> o_output_code == DAC_RESET
        && o_output_ground_clamp && o_output_tristate && !o_code_format_select && o_amp_bypass)
        else $error("reset pin did not restore defaults");
    chk_clamp_tristate: assert property (o_output_ground_clamp |-> o_output_tristate)
        else $error("clamp without tristate");
    chk_clear_steady: assert property (!i_clear_to_preset_n [*8] |-> $stable(o_output_code))
        else $error("output moved while clear held");
    chk_clear_release: assert property ($rose(i_clear_to_preset_n) && i_load_output_n
        && i_frame_sel_n |=> $stable(o_output_code) [*8])
        else $error("output left clear value after release");
    chk_code_quiet: assert property (quiet_q > 4'hC |-> $stable(o_output_code))
        else $error("output code moved without cause");
    chk_format_quiet: assert property (quiet_q > 4'hC |-> $stable(o_code_format_select))
        else $error("format moved without a frame");
    cov_load_fall: cover property (ld_q && !i_load_output_n && i_frame_sel_n);
endmodule

// file: bench/testbench.sv
`timescale 1ns/100ps
module testbench;
    import dac_serial_control_pkg::*;
    logic clk, arst_n, ld_n, preset_n, rst_n, sel_n, sclk, sdi;
    logic dout, oe, clamp, tri_st, fmt, byp;
    logic dout_last_q = 1'b0;
    logic [CODE_W-1:0] code;
    logic [23:0] rd;
    int n_mismatch = 0;
    int n_tests = 0;
    wire logic [3:0] flags = {clamp, tri_st, fmt, byp};
    // no pull on the line: once released it shows the inverse of what was last driven
    wire logic dout_line = oe ? dout : ~dout_last_q;
    always @(posedge clk) begin
        if (oe) begin
            dout_last_q <= dout;
        end
    end
    dac_serial_control dac_serial_control_i (.i_sys_clk(clk), .i_arst_n(arst_n),
        .i_frame_sel_n(sel_n), .i_serial_clk(sclk), .i_serial_data_in(sdi),
        .i_load_output_n(ld_n), .i_clear_to_preset_n(preset_n), .i_reset_n(rst_n),
        .o_serial_data_out(dout), .o_serial_data_out_oe(oe), .o_output_code(code),
        .o_output_ground_clamp(clamp), .o_output_tristate(tri_st),
        .o_code_format_select(fmt), .o_amp_bypass(byp));
    host_model host_model_i (.i_sys_clk(clk), .i_dout(dout_line), .o_sel_n(sel_n), .o_sclk(sclk),
        .o_sdi(sdi));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [19:0] p, input int nf = 24);
        host_model_i.frame({1'b0, a, p}, nf, rd);
    endtask
    task automatic settle();
        repeat (8) @(negedge clk);
    endtask
    task automatic t_defaults();
        check("code", 24'h0, {8'h00, code});
        check("flags", 24'hD, {20'h0, flags});
        $display("defaults done");
    endtask
    task automatic t_writes();
        ld_n = 1'b0;
        wr(ADDR_DAC, {16'hA5C3, 4'hF});
        check("sync code", 24'hA5C3, {8'h00, code});
        wr(ADDR_DAC, 20'h11110, 23);
        check("short frame", 24'hA5C3, {8'h00, code});
        wr(ADDR_DAC, 20'h22220, 25);
        check("long frame", 24'hA5C3, {8'h00, code});
        ld_n = 1'b1;
        wr(ADDR_DAC, 20'h12340);
        check("held code", 24'hA5C3, {8'h00, code});
        ld_n = 1'b0;
        settle();
        check("load code", 24'h1234, {8'h00, code});
        ld_n = 1'b1;
        $display("writes done");
    endtask
    task automatic t_readback();
        host_model_i.frame({1'b1, ADDR_DAC, 20'h0}, 24, rd);
        check("oe idle", 24'h0, {23'h0, oe});
        host_model_i.frame({1'b1, ADDR_CTRL, 20'h0}, 24, rd);
        check("dac read", {1'b1, ADDR_DAC, 16'h1234, 4'h0}, rd);
        host_model_i.frame({1'b1, ADDR_SWCTL, 20'h0}, 24, rd);
        check("ctrl read", {1'b1, ADDR_CTRL, CTRL_RESET}, rd);
        host_model_i.frame({1'b1, ADDR_NO_OPERATION, 20'h0}, 24, rd);
        check("soft read", 24'h0, rd);
        // data-out driver switched off: the line is never driven in the answer frame
        wr(ADDR_CTRL, CTRL_RESET | (20'h00001 << CTRL_DOUT_OFF_BIT));
        host_model_i.frame({1'b1, ADDR_DAC, 20'h0}, 24, rd);
        host_model_i.frame({1'b1, ADDR_NO_OPERATION, 20'h0}, 24, rd);
        check("released line", 24'hFFFFFF, rd);
        $display("readback done");
    endtask
    task automatic t_control();
        wr(ADDR_CTRL, 20'h0);
        check("ctrl zero", 24'h0, {20'h0, flags});
        wr(ADDR_CTRL, 20'h00008);
        check("ctrl tri", 24'h4, {20'h0, flags});
        wr(ADDR_CTRL, 20'h00014);
        check("ctrl clamp", 24'hE, {20'h0, flags});
        $display("control done");
    endtask
    task automatic t_clear();
        wr(ADDR_CLRC, 20'h0F0F0);
        host_model_i.frame({1'b1, ADDR_CLRC, 20'h0}, 24, rd);
        host_model_i.frame({1'b1, ADDR_NO_OPERATION, 20'h0}, 24, rd);
        check("clearcode read", {1'b1, ADDR_CLRC, 16'h0F0F, 4'h0}, rd);
        preset_n = 1'b0;
        ld_n = 1'b0;
        settle();
        check("clear code", 24'h0F0F, {8'h00, code});
        wr(ADDR_DAC, 20'h77770);
        check("blocked code", 24'h0F0F, {8'h00, code});
        ld_n = 1'b1;
        preset_n = 1'b1;
        settle();
        check("after clear", 24'h0F0F, {8'h00, code});
        ld_n = 1'b0;
        wr(ADDR_DAC, 20'h33330);
        wr(ADDR_SWCTL, 20'h00002);
        check("soft clear", 24'h0F0F, {8'h00, code});
        ld_n = 1'b1;
        $display("clear done");
    endtask
    task automatic t_reset();
        rst_n = 1'b0;
        ld_n = 1'b0;
        wr(ADDR_DAC, 20'h55550);
        check("reset code", 24'h0, {8'h00, code});
        check("reset flags", 24'hD, {20'h0, flags});
        rst_n = 1'b1;
        settle();
        wr(ADDR_CTRL, 20'h0);
        wr(ADDR_DAC, 20'h44440);
        check("reset exit", 24'h4444, {8'h00, code});
        wr(ADDR_SWCTL, 20'h00004);
        check("soft reset", 24'h0, {8'h00, code});
        check("soft flags", 24'hD, {20'h0, flags});
        ld_n = 1'b1;
        $display("reset done");
    endtask
    // watchdog: about 24 frames of roughly 22 us each are expected
    initial begin
        #2000000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        arst_n = 1'b0;
        ld_n = 1'b1;
        preset_n = 1'b1;
        rst_n = 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        settle();
        t_defaults();
        t_writes();
        t_readback();
        t_control();
        t_clear();
        t_reset();
        complete_run();
    end
endmodule
bind dac_serial_control dac_serial_control_props dac_serial_control_props_i (.i_sys_clk,
    .i_arst_n, .i_frame_sel_n, .i_serial_clk, .i_serial_data_in, .i_load_output_n,
    .i_clear_to_preset_n, .i_reset_n, .o_serial_data_out, .o_serial_data_out_oe,
    .o_output_code, .o_output_ground_clamp, .o_output_tristate, .o_code_format_select,
    .o_amp_bypass);
